// >>> rtl/sync_sram_cycle_qualifier.sv
// cycle qualification for a pipelined burst sram: select decode, stall,
// burst ordering and sleep control, with a wishbone register port
// assumes control pins come from another domain and the array is outside
`timescale 1ns/10ps
`default_nettype none
`include "sram_qual_cfg.svh"
module sync_sram_cycle_qualifier (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic chip_sel_one_n,
    input wire logic chip_sel_two,
    input wire logic chip_sel_three_n,
    input wire logic clock_qualify_n,
    input wire logic sleep_request,
    input wire logic burst_order,
    input wire logic write_enable_n,
    input wire logic adv_load,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`DATA_W-1:0] dq_in,
    output logic [`DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic [`ADDR_W-1:0] mem_addr,
    output logic mem_write,
    output logic [`DATA_W-1:0] mem_wr_data,
    input wire logic [`DATA_W-1:0] mem_rd_data,
    output logic sleeping,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    localparam int PIN_W = 8 + `ADDR_W + `DATA_W;

    logic [1:0] resetSync;
    logic rst_n;
    logic [PIN_W-1:0] pinMeta;
    logic [PIN_W-1:0] pinSync;
    logic sel1n, sel2, sel3n, qualN, sleepReq, orderPin, weN, advLoad;
    logic [`ADDR_W-1:0] addrS;
    logic [`DATA_W-1:0] dqS;
    logic selected, stall, opLoad, opAdvance, startWrite;
    logic burstWrite, burstLive, readPending;
    logic [`ADDR_W-1:0] baseAddr;
    logic sleepAllow;
    logic [`STALLS_W-1:0] stallCount;
    logic [31:0] next_rdData;
    sram_qual_pkg::phase_t phase;
    sram_qual_pkg::phase_t next_phase;

    burst_if bIf ();

    // release reset through two flops so all logic leaves reset together
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resetSync <= 2'h0;
        end else begin
            resetSync <= {resetSync[0], 1'b1};
        end
    end
    assign rst_n = resetSync[1];

    // every sram-side pin but mem_rd_data is foreign to this clock: two flops before any use
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= {{5{1'b1}}, 3'h0, {(PIN_W-8){1'b0}}};
            pinSync <= {{5{1'b1}}, 3'h0, {(PIN_W-8){1'b0}}};
        end else begin
            pinMeta <= {chip_sel_one_n, chip_sel_three_n, clock_qualify_n,
                        write_enable_n, adv_load, chip_sel_two,
                        sleep_request, burst_order, addr, dq_in};
            pinSync <= pinMeta;
        end
    end
    assign {sel1n, sel3n, qualN, weN, advLoad, sel2, sleepReq, orderPin,
            addrS, dqS} = pinSync;

    assign selected = !sel1n && sel2 && !sel3n;
    assign stall = qualN;
    assign burstLive = phase == sram_qual_pkg::PH_ACTIVE;
    assign opLoad = !stall && burstLive && advLoad && selected;
    assign opAdvance = !stall && burstLive && !advLoad && readPending;
    assign startWrite = opLoad && !weN;

    assign bIf.load = opLoad;
    assign bIf.advance = opAdvance;
    assign bIf.order = sram_qual_pkg::burst_order_t'(orderPin);
    assign bIf.startLow = opLoad ? addrS[`BURST_W-1:0]
                                 : baseAddr[`BURST_W-1:0];

    burst_counter uCount (
        .clock(clock),
        .rst_n(rst_n),
        .bus(bIf.cnt)
    );

    // sleep entry waits for a deselected device and software permission
    always_comb begin
        next_phase = phase;
        case (phase)
            sram_qual_pkg::PH_IDLE: begin
                if (sleepReq && sleepAllow && !selected) begin
                    next_phase = sram_qual_pkg::PH_SLEEP;
                end else begin
                    next_phase = sram_qual_pkg::PH_ACTIVE;
                end
            end
            sram_qual_pkg::PH_ACTIVE: begin
                if (sleepReq && sleepAllow && !selected && !stall) begin
                    next_phase = sram_qual_pkg::PH_SLEEP;
                end
            end
            sram_qual_pkg::PH_SLEEP: begin
                if (!sleepReq) begin
                    next_phase = sram_qual_pkg::PH_WAKE;
                end
            end
            sram_qual_pkg::PH_WAKE: begin
                next_phase = sram_qual_pkg::PH_IDLE;
            end
            default: begin
                next_phase = sram_qual_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= sram_qual_pkg::PH_IDLE;
            sleeping <= 1'b0;
        end else begin
            phase <= next_phase;
            sleeping <= next_phase == sram_qual_pkg::PH_SLEEP;
        end
    end

    // burst state: base address, operation kind, read pipeline
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            baseAddr <= '0;
            burstWrite <= 1'b0;
            readPending <= 1'b0;
        end else if (!burstLive) begin
            readPending <= 1'b0;
        end else if (!stall) begin
            if (opLoad) begin
                baseAddr <= addrS;
                burstWrite <= !weN;
                readPending <= 1'b1;
            end else if (advLoad) begin
                readPending <= 1'b0;
            end
        end
    end

    // array side: address only moves on qualified edges; a stall edge clears the write strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= '0;
            mem_write <= 1'b0;
            mem_wr_data <= '0;
        end else if (stall) begin
            mem_write <= 1'b0;
        end else begin
            if (opLoad) begin
                mem_addr <= {addrS[`ADDR_W-1:`BURST_W], bIf.nextLow};
            end else if (opAdvance) begin
                mem_addr <= {baseAddr[`ADDR_W-1:`BURST_W], bIf.nextLow};
            end
            mem_write <= startWrite || (opAdvance && burstWrite);
            if (startWrite || (opAdvance && burstWrite)) begin
                mem_wr_data <= dqS;
            end
        end
    end

    // data pins: driven only for reads, never while waking or after the first cycle asleep
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else if (!burstLive) begin
            dq_oe <= 1'b0;
        end else if (!stall) begin
            dq_oe <= readPending && !burstWrite && !mem_write;
            dq_out <= mem_rd_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stallCount <= '0;
        end else if (stall && burstLive && stallCount != '1) begin
            stallCount <= stallCount + `STALLS_W'(1);
        end
    end

    // wishbone slave: one wait state, ack for one cycle
    always_comb begin
        next_rdData = `WB_IDLE_DATA;
        if (wb_adr_i == `REG_CTRL) begin
            next_rdData[`CTRL_SLEEP_ALLOW] = sleepAllow;
        end else if (wb_adr_i == `REG_STATUS) begin
            next_rdData[`ST_SELECTED] = selected;
            next_rdData[`ST_SLEEPING] = phase == sram_qual_pkg::PH_SLEEP;
            next_rdData[`ST_STALL] = stall;
            next_rdData[`ST_ORDER] = orderPin;
            next_rdData[`ST_WAKING] = phase == sram_qual_pkg::PH_WAKE;
        end else if (wb_adr_i == `REG_BURST) begin
            next_rdData[`BURST_W-1:0] = bIf.count;
        end else if (wb_adr_i == `REG_STALLS) begin
            next_rdData[`STALLS_W-1:0] = stallCount;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `WB_IDLE_DATA;
            sleepAllow <= `CTRL_RESET;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= wb_we_i ? `WB_IDLE_DATA : next_rdData;
                if (wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL) begin
                    sleepAllow <= wb_dat_i[`CTRL_SLEEP_ALLOW];
                end
            end
        end
    end
endmodule // sync_sram_cycle_qualifier
`default_nettype wire

// >>> rtl/sram_qual_cfg.svh
// constants of the cycle qualifier: register map, fields, reset values
// assumes a 32-bit classic wishbone slave port and a 25 MHz clock
// Summary of operation
// - selected only with select one low, select two high, select three low
// - burst order pin 0 gives linear order, 1 gives interleaved order
// - qualifier high makes the edge a stall; no write happens then
// - data pins stay high impedance when sleep mode is left
`ifndef SRAM_QUAL_CFG_SVH
`define SRAM_QUAL_CFG_SVH

`define ADDR_W 18
`define DATA_W 8
`define BURST_W 2

`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_BURST 4'h8
`define REG_STALLS 4'hC

`define CTRL_SLEEP_ALLOW 0
`define CTRL_RESET 1'h1

`define ST_SELECTED 0
`define ST_SLEEPING 1
`define ST_STALL 2
`define ST_ORDER 3
`define ST_WAKING 4

`define STALLS_W 16
`define WB_IDLE_DATA 32'h00000000

`endif

// >>> rtl/sram_qual_pkg.sv
// types shared by the cycle qualifier modules
// assumes nothing beyond the constants header
package sram_qual_pkg;
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_ACTIVE = 4'b0010,
        PH_SLEEP = 4'b0100,
        PH_WAKE = 4'b1000
    } phase_t;

    typedef enum logic {
        ORDER_LINEAR = 1'b0,
        ORDER_INTERLEAVED = 1'b1
    } burst_order_t;
endpackage

// >>> rtl/burst_if.sv
// carrier between the qualifier and its burst counter
// assumes both ends run on the same clock and reset
`timescale 1ns/10ps
`default_nettype none
`include "sram_qual_cfg.svh"
interface burst_if;
    logic load;
    logic advance;
    sram_qual_pkg::burst_order_t order;
    logic [`BURST_W-1:0] startLow;
    logic [`BURST_W-1:0] nextLow;
    logic [`BURST_W-1:0] count;

    modport ctl (output load, output advance, output order,
                 output startLow, input nextLow, input count);
    modport cnt (input load, input advance, input order,
                 input startLow, output nextLow, output count);
endinterface
`default_nettype wire

// >>> rtl/burst_counter.sv
// burst position counter with linear or interleaved ordering
// assumes load and advance are only raised on qualified edges
`timescale 1ns/10ps
`default_nettype none
`include "sram_qual_cfg.svh"
module burst_counter (
    input wire logic clock,
    input wire logic rst_n,
    burst_if.cnt bus
);
    logic [`BURST_W-1:0] next_count;

    function automatic logic [`BURST_W-1:0] orderLow(
        input sram_qual_pkg::burst_order_t ord,
        input logic [`BURST_W-1:0] start,
        input logic [`BURST_W-1:0] step);
        if (ord == sram_qual_pkg::ORDER_INTERLEAVED) begin
            orderLow = start ^ step;
        end else begin
            orderLow = start + step;
        end
    endfunction

    always_comb begin
        if (bus.load) begin
            next_count = '0;
        end else if (bus.advance) begin
            next_count = bus.count + `BURST_W'(1);
        end else begin
            next_count = bus.count;
        end
    end

    assign bus.nextLow = orderLow(bus.order, bus.startLow, next_count);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus.count <= '0;
        end else begin
            bus.count <= next_count;
        end
    end
endmodule // burst_counter
`default_nettype wire

// >>> dv/sram_qual_props.sv
// checker on the qualifier's pins: select, stall, burst and sleep
// assumes pins pass two sync flops, so a pin shows 3 edges later
`timescale 1ns/10ps
`default_nettype none
`include "sram_qual_cfg.svh"
module sram_qual_props (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic chip_sel_one_n,
    input wire logic chip_sel_two,
    input wire logic chip_sel_three_n,
    input wire logic clock_qualify_n,
    input wire logic adv_load,
    input wire logic burst_order,
    input wire logic [`ADDR_W-1:0] mem_addr,
    input wire logic mem_write,
    input wire logic dq_oe,
    input wire logic sleeping
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    chk_sel_load: assert property (
        $past(adv_load, 3) && !(!$past(chip_sel_one_n, 3)
            && $past(chip_sel_two, 3) && !$past(chip_sel_three_n, 3))
            |-> !mem_write)
        else $error("write loaded while deselected");
    chk_stall_nowrite: assert property (
        mem_write |-> !$past(clock_qualify_n, 3))
        else $error("write on a stalled edge");
    chk_stall_hold: assert property (
        $past(clock_qualify_n, 3) |-> $stable(mem_addr) && $stable(dq_oe))
        else $error("outputs moved on a stalled edge");
    // only linear order steps by one from any start, so only it is here
    chk_burst_step: assert property (
        !$past(clock_qualify_n, 3) && !$past(adv_load, 3)
            && !$past(burst_order, 3) && $changed(mem_addr)
            |-> mem_addr[1:0] == $past(mem_addr[1:0]) + 2'h1)
        else $error("linear burst did not step by one");
    chk_wake_quiet: assert property (
        $fell(sleeping) |-> !dq_oe [*2])
        else $error("data driven right after sleep");
endmodule // sram_qual_props

bind sync_sram_cycle_qualifier sram_qual_props u_props (.*);
`default_nettype wire

// >>> dv/ctrl_model.sv
// controller model: drives select, qualifier, burst and data pins and
// serves array reads; assumes the block's clock, no reset of its own
`timescale 1ns/10ps
`default_nettype none
`include "sram_qual_cfg.svh"
module ctrl_model (
    input wire logic clock,
    input wire logic [`ADDR_W-1:0] mem_addr,
    output var logic chip_sel_one_n,
    output var logic chip_sel_two,
    output var logic chip_sel_three_n,
    output var logic clock_qualify_n,
    output var logic write_enable_n,
    output var logic adv_load,
    output var logic sleep_request,
    output var logic [`ADDR_W-1:0] addr,
    output var logic [`DATA_W-1:0] dq_in,
    output logic [`DATA_W-1:0] mem_rd_data
);
    assign mem_rd_data = mem_addr[7:0] ^ 8'hA5;
    initial {chip_sel_one_n, chip_sel_two, chip_sel_three_n,
        clock_qualify_n, write_enable_n, adv_load, sleep_request,
        addr, dq_in} = {7'h76, 26'h0};

    // one beat, then stall edges so results can be looked at at leisure
    task automatic beat(input logic [2:0] s, input logic q,
                        input logic w, input logic adv,
                        input logic [`ADDR_W-1:0] a);
        @(posedge clock);
        {chip_sel_one_n, chip_sel_two, chip_sel_three_n, clock_qualify_n,
            write_enable_n, adv_load, addr} <= {s, q, w, adv, a};
        dq_in <= a[7:0];
        @(posedge clock);
        clock_qualify_n <= 1'h1;
        dq_in <= ~a[7:0];
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic nap(input logic on);
        @(posedge clock);
        {chip_sel_one_n, chip_sel_two, chip_sel_three_n, clock_qualify_n,
            adv_load} <= 5'h1D;
        if (on) begin
            @(posedge clock);
            sleep_request <= 1'h1;
        end else
            sleep_request <= 1'h0;
    endtask
endmodule // ctrl_model
`default_nettype wire

// >>> dv/testbench.sv
// bench: controller model on the pins, wishbone tasks on the registers
// assumes one 25 MHz clock and the block's two-flop reset release
`timescale 1ns/10ps
`default_nettype none
`include "sram_qual_cfg.svh"
module testbench;
    logic clock = 1'b0;
    logic reset_n, chip_sel_one_n, chip_sel_two, chip_sel_three_n;
    logic clock_qualify_n, sleep_request, burst_order, write_enable_n;
    logic adv_load, dq_oe, mem_write, sleeping, wb_cyc_i, wb_stb_i;
    logic wb_we_i, wb_ack_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [`ADDR_W-1:0] addr, mem_addr;
    logic [`DATA_W-1:0] dq_in, dq_out, mem_wr_data, mem_rd_data;
    logic [31:0] wb_dat_i, wb_dat_o, r;
    logic [1:0] e, p;
    int err_count = 0, n_checks = 0, nWrites = 0, w0, k;

    always #20 clock = ~clock;
    always @(posedge clock) if (mem_write === 1'b1) nWrites++;
    ctrl_model ctl (.*);
    sync_sram_cycle_qualifier dut (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wbx(input logic w, input logic [3:0] a);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, w, a};
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        chk(k < 20, 32'h1);
    endtask

    task automatic t_select;
        for (int i = 0; i < 8; i++) begin
            w0 = nWrites;
            ctl.beat(i[2:0], 1'h0, 1'h0, 1'h1, 18'h00011);
            chk(nWrites - w0, i == 2);
        end
        chk(mem_wr_data, 32'h11);
        w0 = nWrites;
        ctl.beat(3'h2, 1'h1, 1'h0, 1'h1, 18'h00022);
        chk(nWrites - w0, 32'h0);
        chk(mem_addr, 32'h11);
        // a write burst: the advance beat must write as well
        w0 = nWrites;
        ctl.beat(3'h2, 1'h0, 1'h0, 1'h1, 18'h00033);
        ctl.beat(3'h2, 1'h0, 1'h1, 1'h0, 18'h00033);
        chk(nWrites - w0, 32'h2);
        chk({mem_addr, mem_wr_data}, {18'h00030, 8'h33});
        $display("select and stall done");
    endtask

    task automatic t_burst;
        w0 = nWrites;
        for (int o = 0; o < 2; o++) begin
            @(posedge clock);
            burst_order <= o[0];
            repeat (3) @(posedge clock);
            for (int n = 0; n < 4; n++) begin
                p = e;
                ctl.beat(3'h2, 1'h0, 1'h1, n == 0, 18'h00155);
                e = o[0] ? 2'h1 ^ n[1:0] : 2'h1 + n[1:0];
                chk(mem_addr, {16'h0055, e});
                // one qualified edge per beat: read data of the previous beat
                if (n > 0) begin
                    chk({dq_oe, dq_out}, {1'b1, 6'h15, p} ^ 9'h0A5);
                end
            end
        end
        chk(nWrites - w0, 32'h0);
        wbx(1'h0, `REG_BURST);
        chk(r, 32'h3);
        wbx(1'h0, `REG_STATUS);
        chk(r, 32'hD);
        // pins stay stalled; two back-to-back takes lie three edges apart
        wbx(1'h0, `REG_STALLS);
        w0 = r;
        wbx(1'h0, `REG_STALLS);
        chk(r - w0, 32'h3);
        $display("burst order done");
    endtask

    task automatic t_sleep;
        wbx(1'h0, `REG_CTRL);
        chk(r, 32'h1);
        wbx(1'h0, 4'h2);
        chk(r, 32'h0);
        for (int s = 1; s >= 0; s--) begin
            ctl.nap(s[0]);
            for (k = 0; k < 40 && sleeping !== s[0]; k++) @(posedge clock);
            #1 chk(sleeping, s[0]);
            wbx(1'h0, `REG_STATUS);
            chk(r[1], s[0]);
        end
        repeat (2) @(posedge clock);
        #1 chk(dq_oe, 32'h0);
        wbx(1'h1, `REG_CTRL);
        chk(r, 32'h0);
        wbx(1'h0, `REG_CTRL);
        chk(r, 32'h0);
        ctl.nap(1'h1);
        repeat (12) @(posedge clock);
        #1 chk(sleeping, 32'h0);
        ctl.nap(1'h0);
        $display("registers and sleep done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {reset_n, burst_order, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h0F, 32'h0};
        repeat (8) @(posedge clock);
        reset_n <= 1'h1;
        repeat (3) @(posedge clock);
        t_select;
        t_burst;
        t_sleep;
        close_out;
    end

    // the whole sequence needs well under 1000 cycles
    initial begin
        #200000;
        err_count++;
        close_out;
    end
endmodule // testbench
`default_nettype wire
